//--- logic/lrc_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 50 MHz reference clock
// Notes: Offsets are register indices on the device's own register port
`ifndef LRC_MAP_VH
`define LRC_MAP_VH
`define LRC_OFS_RESULT 8'h00
`define LRC_OFS_CONFIG 8'h01
`define LRC_RESULT_RST 16'h0000
`define LRC_CONFIG_RST 16'hC810
`define LRC_F_RANGE_HI 15
`define LRC_F_RANGE_LO 12
`define LRC_F_SPAN 11
`define LRC_F_MODE_HI 10
`define LRC_F_MODE_LO 9
`define LRC_F_OVF 8
`define LRC_F_CRF 7
`define LRC_F_FH 6
`define LRC_F_FL 5
`define LRC_F_LATCH 4
`define LRC_F_POL 3
`define LRC_F_ME 2
`define LRC_F_FC_HI 1
`define LRC_F_FC_LO 0
`define LRC_RANGE_AUTO 4'hC
`define LRC_EXP_MAX 4'hB
`define LRC_MODE_OFF 2'h0
`define LRC_MODE_SINGLE 2'h1
`define LRC_CLK_HZ 50000000
`define LRC_SHORT_MS 100
`define LRC_LONG_MS 800
`define LRC_SHORT_CYC ((`LRC_CLK_HZ / 1000) * `LRC_SHORT_MS)
`define LRC_LONG_CYC ((`LRC_CLK_HZ / 1000) * `LRC_LONG_MS)
`define LRC_MANT_FULL 12'hFFF
`define LRC_MANT_HALF 12'h7FF
`endif

//--- logic/lrc_range_pick.v
// Purpose: Choose the exponent for a finished conversion
// Assumes: Raw sample is an unscaled count at the finest range
// Notes: Combinational; exponent never above the top code
`timescale 1ns/1ps
`include "lrc_map.vh"
module lrc_range_pick (
  input wire [3:0] i_range_sel,
  input wire [23:0] i_raw,
  output reg [3:0] o_exp,
  output reg [11:0] o_mant,
  output reg o_ovf
);
  integer k;
  reg [3:0] e;
  reg [23:0] sh;
  always @* begin
    e = 4'h0;
    sh = 24'h000000;
    o_ovf = 1'b0;
    if (i_range_sel >= `LRC_RANGE_AUTO) begin
      // Smallest exponent whose mantissa fits
      e = `LRC_EXP_MAX;
      for (k = 11; k >= 0; k = k - 1) begin
        if ((i_raw >> k) <= {12'h000, `LRC_MANT_FULL}) begin
          e = k[3:0];
        end
      end
    end else if (i_range_sel > `LRC_EXP_MAX) begin
      e = `LRC_EXP_MAX; // [RULE_14]
    end else begin
      e = i_range_sel;
    end
    sh = i_raw >> e;
    if (sh > {12'h000, `LRC_MANT_FULL}) begin
      o_ovf = 1'b1;
      o_mant = `LRC_MANT_FULL; // [RULE_03]
    end else begin
      o_mant = sh[11:0]; // [RULE_03]
    end
    o_exp = e; // [RULE_04] [RULE_14]
  end
endmodule

//--- logic/lrc_light_regs.v
// Purpose: Result and configuration registers of a light sensor readout
// Assumes: Register port is a simple word strobe interface from the serial slave
// Notes: Conversion length set by the span bit; raw sample taken at the end
//
// Functional notes
// RULE_01: Result holds exponent in bits 15:12, mantissa in bits 11:0.
// RULE_02: Result always shows the latest completed conversion.
// RULE_03: Mantissa is unsigned binary from zero to full scale.
// RULE_04: Exponents 0 to 11 double range from 40.95 lux, LSB 0.01 lux.
// RULE_05: Host computes lux as 0.01 times two to exponent times mantissa.
// RULE_06: Mask bit with manual range below 1100b reads exponent as zero.
// RULE_07: Configuration register at 01h resets to C810h.
// RULE_08: Any configuration write aborts a running conversion at once.
// RULE_09: If new settings ask for conversion, a fresh one starts.
// RULE_10: Configuration holds eleven fields, status bits 8 to 5 read-only.
// RULE_11: Mode 00 off, 01 single-shot, 1x continuous; single returns to 00.
// RULE_12: Range 1100b selects automatic ranging; 1101b-1111b reserved.
// RULE_13: Span bit clear gives 100 ms conversion, set gives 800 ms.
// RULE_14: Exponent codes above 1011b never reach the result register.
`timescale 1ns/1ps
`include "lrc_map.vh"
module lrc_light_regs #(
  parameter SHORT_CYC = `LRC_SHORT_CYC,
  parameter LONG_CYC = `LRC_LONG_CYC
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_ack,
  input wire [23:0] i_light_raw,
  input wire i_high_limit_hit,
  input wire i_low_limit_hit,
  output wire o_converting,
  output wire o_conv_done
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg state_reg, state_next;
  reg [31:0] cnt_reg, cnt_next;
  reg [15:0] result_reg, result_next;
  reg [3:0] full_scale_range_sel_reg;
  reg integration_span_reg;
  reg [1:0] mode_reg, mode_next;
  reg overflow_flag_reg, overflow_flag_next;
  reg conv_ready_flag_reg, conv_ready_flag_next;
  reg high_limit_flag_reg, high_limit_flag_next;
  reg low_limit_flag_reg, low_limit_flag_next;
  reg [4:0] low_ctl_reg;
  reg done_reg;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [3:0] pick_exp;
  wire [11:0] pick_mant;
  wire pick_ovf;
  wire cfg_wr = i_reg_wr && (i_reg_addr == `LRC_OFS_CONFIG);
  wire [1:0] wmode = i_reg_wdata[`LRC_F_MODE_HI:`LRC_F_MODE_LO];
  wire wspan = i_reg_wdata[`LRC_F_SPAN];
  wire exp_mask_en = low_ctl_reg[`LRC_F_ME];
  wire [31:0] span_cyc = integration_span_reg ? LONG_CYC : SHORT_CYC; // [RULE_13]
  wire [31:0] wspan_cyc = wspan ? LONG_CYC : SHORT_CYC; // [RULE_13]
  wire [3:0] res_exp;
  wire [15:0] cfg_rst = `LRC_CONFIG_RST;
  wire [15:0] cfg_word;

  lrc_range_pick u_pick (
    .i_range_sel(full_scale_range_sel_reg), // [RULE_12]
    .i_raw(i_light_raw),
    .o_exp(pick_exp),
    .o_mant(pick_mant),
    .o_ovf(pick_ovf)
  );

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    result_next = result_reg;
    mode_next = mode_reg;
    overflow_flag_next = overflow_flag_reg;
    conv_ready_flag_next = conv_ready_flag_reg;
    high_limit_flag_next = high_limit_flag_reg;
    low_limit_flag_next = low_limit_flag_reg;
    case (state_reg)
      ST_IDLE: begin
        if (mode_reg != `LRC_MODE_OFF) begin
          state_next = ST_CONV;
          cnt_next = span_cyc - 32'h00000001;
        end
      end
      ST_CONV: begin
        if (cnt_reg == 32'h00000000) begin
          result_next = {pick_exp, pick_mant}; // [RULE_01] [RULE_02]
          overflow_flag_next = pick_ovf;
          conv_ready_flag_next = 1'b1;
          high_limit_flag_next = high_limit_flag_reg | i_high_limit_hit;
          low_limit_flag_next = low_limit_flag_reg | i_low_limit_hit;
          if (mode_reg == `LRC_MODE_SINGLE) begin
            mode_next = `LRC_MODE_OFF; // [RULE_11]
            state_next = ST_IDLE;
          end else begin
            cnt_next = span_cyc - 32'h00000001; // [RULE_11]
          end
        end else begin
          cnt_next = cnt_reg - 32'h00000001;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (cfg_wr) begin
      mode_next = wmode; // [RULE_10]
      if (wmode != `LRC_MODE_OFF) begin
        state_next = ST_CONV; // [RULE_09]
        cnt_next = wspan_cyc - 32'h00000001;
      end else begin
        state_next = ST_IDLE; // [RULE_08]
      end
    end
    if (i_reg_rd && (i_reg_addr == `LRC_OFS_CONFIG)) begin
      conv_ready_flag_next = (state_reg == ST_CONV) && (cnt_reg == 32'h00000000);
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 32'h00000000;
      result_reg <= `LRC_RESULT_RST;
      full_scale_range_sel_reg <= cfg_rst[`LRC_F_RANGE_HI:`LRC_F_RANGE_LO]; // [RULE_07] [RULE_12]
      integration_span_reg <= cfg_rst[`LRC_F_SPAN];
      mode_reg <= cfg_rst[`LRC_F_MODE_HI:`LRC_F_MODE_LO];
      overflow_flag_reg <= 1'b0;
      conv_ready_flag_reg <= 1'b0;
      high_limit_flag_reg <= 1'b0;
      low_limit_flag_reg <= 1'b0;
      low_ctl_reg <= cfg_rst[`LRC_F_LATCH:`LRC_F_FC_LO]; // [RULE_07]
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      result_reg <= result_next;
      mode_reg <= mode_next;
      overflow_flag_reg <= overflow_flag_next;
      conv_ready_flag_reg <= conv_ready_flag_next;
      high_limit_flag_reg <= high_limit_flag_next;
      low_limit_flag_reg <= low_limit_flag_next;
      done_reg <= (state_reg == ST_CONV) && (cnt_reg == 32'h00000000) && !cfg_wr;
      if (cfg_wr) begin
        full_scale_range_sel_reg <= i_reg_wdata[`LRC_F_RANGE_HI:`LRC_F_RANGE_LO]; // [RULE_10]
        integration_span_reg <= wspan; // [RULE_10]
        low_ctl_reg <= i_reg_wdata[`LRC_F_LATCH:`LRC_F_FC_LO]; // [RULE_10]
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign res_exp = (exp_mask_en && (full_scale_range_sel_reg < `LRC_RANGE_AUTO)) ?
    4'h0 : result_reg[15:12]; // [RULE_06]

  // Status bits 8 to 5 come from the sequencer, never from a write
  assign cfg_word = {
    full_scale_range_sel_reg,
    integration_span_reg,
    mode_reg,
    overflow_flag_reg,
    conv_ready_flag_reg,
    high_limit_flag_reg,
    low_limit_flag_reg,
    low_ctl_reg
  }; // [RULE_10]

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `LRC_OFS_RESULT: o_reg_rdata <= {res_exp, result_reg[11:0]}; // [RULE_01]
          `LRC_OFS_CONFIG: o_reg_rdata <= cfg_word; // [RULE_10]
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign o_converting = (state_reg == ST_CONV);
  assign o_conv_done = done_reg;
endmodule

//--- dv/lrc_light_regs_asserts.sv
// Purpose: Port checks for the light register block
// Assumes: One clock, sync reset
// Notes: Bound to the block
`timescale 1ns/1ps
module lrc_light_regs_asserts #(
  parameter SHORT_CYC = 20,
  parameter LONG_CYC = 50
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_ack,
  input wire o_converting,
  input wire o_conv_done
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire cfg_wr = i_reg_wr && i_reg_addr == 8'h01;
  a_ack_follows: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("ack missing");
  a_ack_cause: assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr))
    else $error("ack without request");
  a_unmapped_zero: assert property ((i_reg_rd && i_reg_addr > 8'h01) |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_exp_bound: assert property ((i_reg_rd && i_reg_addr == 8'h00) |=> o_reg_rdata[15:12] <= 4'hB)
    else $error("exponent above top code");
  a_wr_abort: assert property ((cfg_wr && i_reg_wdata[10:9] == 2'h0) |=> !o_converting)
    else $error("conversion not stopped");
  a_wr_start: assert property ((cfg_wr && i_reg_wdata[10:9] != 2'h0) |=> o_converting [*8])
    else $error("conversion not started");
  a_done_cause: assert property (o_conv_done |-> $past(o_converting, 2))
    else $error("done without conversion");
  a_done_pulse: assert property (o_conv_done |=> !o_conv_done)
    else $error("done longer than one cycle");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
endmodule
bind lrc_light_regs lrc_light_regs_asserts #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_ack(o_reg_ack), .o_converting(o_converting), .o_conv_done(o_conv_done));

//--- dv/lrc_light_src.sv
// Purpose: Light front end model feeding raw counts and limit levels
// Assumes: Levels set by the bench
// Notes: Registered like a sampling front end
`timescale 1ns/1ps
module lrc_light_src (
  input wire i_ref_clk,
  input wire [23:0] i_level,
  input wire i_high,
  input wire i_low,
  output reg [23:0] o_light_raw,
  output reg o_high_limit_hit,
  output reg o_low_limit_hit
);
  always @(posedge i_ref_clk) begin
    o_light_raw <= i_level;
    o_high_limit_hit <= i_high;
    o_low_limit_hit <= i_low;
  end
endmodule

//--- dv/lrc_light_regs_tb_top.sv
// Purpose: Self-checking bench for the light registers
// Assumes: Short conversion counts
// Notes: Register port driven by tasks
`timescale 1ns/1ps
module lrc_light_regs_tb_top;
  reg i_ref_clk = 0;
  reg i_rst = 1;
  reg [7:0] i_reg_addr = 0;
  reg i_reg_wr = 0;
  reg i_reg_rd = 0;
  reg [15:0] i_reg_wdata = 0;
  reg [23:0] level = 0;
  reg hi = 0;
  reg lo = 0;
  wire [15:0] o_reg_rdata;
  wire o_reg_ack, o_converting, o_conv_done, high_hit, low_hit;
  wire [23:0] raw;
  int num_errors = 0;
  int check_count = 0;
  reg [23:0] raws [0:3] = '{24'h000456, 24'h001000, 24'h7FF800, 24'hFFFFFF};
  reg [15:0] res [0:3] = '{16'h0456, 16'h1800, 16'hBFFF, 16'hBFFF};
  reg [15:0] cfg [0:3] = '{16'hC080, 16'hC080, 16'hC080, 16'hC180};
  initial forever #10 i_ref_clk = ~i_ref_clk;
  lrc_light_src u_src (.i_ref_clk(i_ref_clk), .i_level(level), .i_high(hi), .i_low(lo),
    .o_light_raw(raw), .o_high_limit_hit(high_hit), .o_low_limit_hit(low_hit));
  lrc_light_regs #(.SHORT_CYC(20), .LONG_CYC(50)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
    .i_light_raw(raw), .i_high_limit_hit(high_hit), .i_low_limit_hit(low_hit),
    .o_converting(o_converting), .o_conv_done(o_conv_done));
  // ----------
  // Tasks
  // ----------
  task chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input w, input [7:0] a, input [15:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= w;
    i_reg_rd <= !w;
    @(posedge i_ref_clk);
    i_reg_wr <= 0;
    i_reg_rd <= 0;
    @(posedge i_ref_clk);
    chk({15'h0, o_reg_ack}, 16'h0001);
  endtask
  task rd(input [7:0] a, input [15:0] e);
    acc(0, a, 16'h0000);
    chk(o_reg_rdata, e);
  endtask
  task wdone;
    int n;
    n = 0;
    @(posedge i_ref_clk);
    while (o_conv_done !== 1'b1 && n < 200) begin
      @(posedge i_ref_clk);
      n++;
    end
    chk({15'h0, o_conv_done}, 16'h0001);
  endtask
  task give_verdict;
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 0;
    rd(8'h01, 16'hC810);
    rd(8'h00, 16'h0000);
    rd(8'h05, 16'h0000);
    acc(1, 8'h00, 16'h1234);
    rd(8'h00, 16'h0000);
    acc(1, 8'h01, 16'h01FF);
    rd(8'h01, 16'h001F);
    for (int k = 0; k < 4; k++) begin
      level <= raws[k];
      acc(1, 8'h01, 16'hC200);
      wdone;
      rd(8'h00, res[k]);
      rd(8'h01, cfg[k]);
    end
    level <= 24'h0022B0;
    acc(1, 8'h01, 16'h3204);
    wdone;
    rd(8'h00, 16'h0456);
    acc(1, 8'h01, 16'h3200);
    wdone;
    rd(8'h00, 16'h3456);
    acc(1, 8'h01, 16'hC600);
    repeat (10) @(posedge i_ref_clk);
    acc(1, 8'h01, 16'hC000);
    chk({15'h0, o_converting}, 16'h0000);
    repeat (60) @(posedge i_ref_clk);
    rd(8'h00, 16'h3456);
    acc(1, 8'h01, 16'hCA00);
    repeat (30) @(posedge i_ref_clk);
    chk({15'h0, o_converting}, 16'h0001);
    wdone;
    rd(8'h00, 16'h28AC);
    hi <= 1;
    lo <= 1;
    acc(1, 8'h01, 16'hC400);
    wdone;
    wdone;
    rd(8'h01, 16'hC4E0);
    rd(8'h00, 16'h28AC);
    acc(1, 8'h01, 16'hC000);
    give_verdict;
  end
endmodule
